//--- rtl/ocr_pkg.sv
// package: register map, field layout and carriers of the output clock routing block
package ocr_pkg;
   // --------------------------------------------------------------
   // register offsets and reset values
   // --------------------------------------------------------------
   localparam logic [3:0] ADDR_CHAN_CTL = 4'h3;
   localparam logic [3:0] ADDR_FMT_CTL = 4'h6;
   localparam logic [3:0] ADDR_OUT_CTL = 4'h7;
   localparam logic [15:0] RST_CHAN_CTL = 16'h1801;
   localparam logic [15:0] RST_FMT_CTL = 16'h0aa0;
   localparam logic [15:0] RST_OUT_CTL = 16'h6503;
   localparam logic [15:0] OUT_CTL_RSVD_MASK = 16'h7fff;
   // --------------------------------------------------------------
   // channel control fields
   // --------------------------------------------------------------
   localparam int CH1_SRC_POS = 8;
   localparam int CH1_COMB_POS = 7;
   localparam int SEC_IDLE_POS = 6;
   localparam int FIRST_IDLE_POS = 5;
   localparam int CH0_SRC_POS = 4;
   localparam int CH0_COMB_POS = 3;
   localparam int CH0_RATIO_LSB = 0;
   // --------------------------------------------------------------
   // divider / format control fields
   // --------------------------------------------------------------
   localparam int CH1_RATIO_LSB = 13;
   localparam int SEC_NUM_HI_LSB = 5;
   localparam int FIRST_RATE_LSB = 3;
   localparam int FIRST_FMT_LSB = 0;
   // --------------------------------------------------------------
   // output control fields
   // --------------------------------------------------------------
   localparam int AUX_FUNC_LSB = 13;
   localparam int AUX_DIV_LSB = 11;
   localparam int AUX_SRC_POS = 9;
   localparam int SEC_ON_POS = 8;
   localparam int SEC_ROUTE_POS = 7;
   localparam int SEC_RATE_LSB = 5;
   localparam int SEC_FMT_LSB = 2;
   localparam int FIRST_ON_POS = 1;
   localparam int OE_POL_POS = 0;
   // --------------------------------------------------------------
   // encodings
   // --------------------------------------------------------------
   localparam logic [2:0] FMT_CMOS_POS = 3'h4;
   localparam logic [2:0] FMT_CMOS_NEG = 3'h5;
   localparam logic [2:0] FMT_CMOS_ANTI = 3'h6;
   localparam logic [2:0] FMT_CMOS_SAME = 3'h7;
   localparam logic [1:0] AUX_GND = 2'h0;
   localparam logic [1:0] AUX_TRI = 2'h1;
   localparam logic [1:0] AUX_REFCLK = 2'h2;
   localparam logic [1:0] AUX_READY = 2'h3;

   // one pad: drive value and output enable (low while driving)
   typedef struct packed {
      logic drv;
      logic oeN;
   } ocr_pin_t;

   typedef struct packed {
      ocr_pin_t pos;
      ocr_pin_t neg;
   } ocr_pair_t;
endpackage : ocr_pkg

//--- rtl/ocr_output_clock_routing.sv
// module: output clock routing, format and enable control with its register file
`timescale 1ns/1ps

// Function
// - channel one ratio 0 off, else divide by 2,4,6,8,10,20,40
// - bits 12:5 hold second fractional numerator high byte, default 0x55
// - first output edge rate 0 fastest to 3 slowest, differential only
// - first output format selects HCSL, LVDS or single-ended variants
// - codes 4-7: positive only, negative only, antiphase, in phase
// - aux pin: ground, tri-state, reference clock, or clock ready
// - aux divider 0 off, else divide by 2, 4, 8
// - bit 9 picks fractional divider feeding aux reference clock
// - bit 8 enables second output, default one
// - bit 7 routes second output from channel zero or one
// - second output edge rate, fastest at 0, differential only
// - second output format uses same encoding as first
// - bit 1 enables first output, default one
// - bit 0 sets enable pin polarity only, default active low
// - configuration fields load defaults from fuse storage
// - disabled output pins grounded when idle bit 0, tri-stated when 1
// - combiner flag feeds driver from channel divider or edge combiner
// - channel one source pick selects first or second fractional divider
module ocr_output_clock_routing #(
   parameter int CNT_W = 5
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [3:0] regAddr,
   input wire logic regWrEn,
   input wire logic [15:0] regWrData,
   output logic [15:0] regRdData,
   input wire logic [15:0] fuseChanCtl,
   input wire logic [15:0] fuseFmtCtl,
   input wire logic [15:0] fuseOutCtl,
   input wire logic fracClkZero,
   input wire logic fracClkOne,
   input wire logic combinerClk,
   input wire logic outEnablePin,
   input wire logic clockReady,
   output ocr_pkg::ocr_pair_t firstClockOutput,
   output ocr_pkg::ocr_pair_t secondClockOutput,
   output ocr_pkg::ocr_pin_t auxPin,
   output logic [2:0] firstDrvFormat,
   output logic [2:0] secondDrvFormat,
   output logic [1:0] firstEdgeRate,
   output logic [1:0] secondEdgeRate
);
   // -----------------------------------------------------------------
   // decode functions
   // -----------------------------------------------------------------
   function automatic logic [CNT_W-1:0] ratioHalf(input logic [2:0] code);
      case (code)
         3'h6: ratioHalf = CNT_W'(10);
         3'h7: ratioHalf = CNT_W'(20);
         default: ratioHalf = CNT_W'(code);
      endcase
   endfunction : ratioHalf

   function automatic logic [CNT_W-1:0] auxHalf(input logic [1:0] code);
      case (code)
         2'h3: auxHalf = CNT_W'(4);
         default: auxHalf = CNT_W'(code);
      endcase
   endfunction : auxHalf

   function automatic ocr_pkg::ocr_pin_t idlePin(input logic tri3);
      idlePin.drv = 1'b0;
      idlePin.oeN = tri3;
   endfunction : idlePin

   function automatic ocr_pkg::ocr_pin_t drivePin(input logic v);
      drivePin.drv = v;
      drivePin.oeN = 1'b0;
   endfunction : drivePin

   // pin pair for one output from its enable, format, clock and idle choice
   function automatic ocr_pkg::ocr_pair_t pairOut(input logic on, input logic [2:0] fmt,
                                                  input logic ck, input logic idle);
      pairOut.pos = idlePin(idle);
      pairOut.neg = idlePin(idle);
      if (on) begin
         case (fmt)
            ocr_pkg::FMT_CMOS_POS: pairOut.pos = drivePin(ck);
            ocr_pkg::FMT_CMOS_NEG: pairOut.neg = drivePin(ck);
            ocr_pkg::FMT_CMOS_SAME: begin
               pairOut.pos = drivePin(ck);
               pairOut.neg = drivePin(ck);
            end
            default: begin
               pairOut.pos = drivePin(ck);
               pairOut.neg = drivePin(~ck);
            end
         endcase
      end
   endfunction : pairOut

   // -----------------------------------------------------------------
   // register file with fuse load
   // -----------------------------------------------------------------
   logic [15:0] chanCtl_reg;
   logic [15:0] fmtCtl_reg;
   logic [15:0] outCtl_reg;
   logic fuseLoaded_reg;
   wire logic wrChan = regWrEn && regAddr == ocr_pkg::ADDR_CHAN_CTL;
   wire logic wrFmt = regWrEn && regAddr == ocr_pkg::ADDR_FMT_CTL;
   wire logic wrOut = regWrEn && regAddr == ocr_pkg::ADDR_OUT_CTL;
   wire logic [15:0] rdMux = regAddr == ocr_pkg::ADDR_CHAN_CTL ? chanCtl_reg :
                             regAddr == ocr_pkg::ADDR_FMT_CTL ? fmtCtl_reg :
                             regAddr == ocr_pkg::ADDR_OUT_CTL ? outCtl_reg : 16'h0000;

   // fuse copy lands on the first edge after reset release; a write in
   // that same cycle is dropped so the stored defaults are never torn
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         chanCtl_reg <= ocr_pkg::RST_CHAN_CTL;
         fmtCtl_reg <= ocr_pkg::RST_FMT_CTL;
         outCtl_reg <= ocr_pkg::RST_OUT_CTL;
         fuseLoaded_reg <= 1'b0;
      end else if (!fuseLoaded_reg) begin
         chanCtl_reg <= fuseChanCtl;
         fmtCtl_reg <= fuseFmtCtl;
         outCtl_reg <= fuseOutCtl & ocr_pkg::OUT_CTL_RSVD_MASK;
         fuseLoaded_reg <= 1'b1;
      end else begin
         if (wrChan) chanCtl_reg <= regWrData;
         if (wrFmt) fmtCtl_reg <= regWrData;
         if (wrOut) outCtl_reg <= regWrData & ocr_pkg::OUT_CTL_RSVD_MASK;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) regRdData <= 16'h0000;
      else regRdData <= rdMux;
   end

   // -----------------------------------------------------------------
   // pin synchronisers: 0 frac zero, 1 frac one, 2 combiner, 3 enable pin
   // -----------------------------------------------------------------
   logic [3:0] syncA_reg;
   logic [3:0] syncB_reg;
   logic [3:0] syncC_reg;
   logic [3:0] pinLvl_reg;
   wire logic [3:0] pinRaw = {outEnablePin, combinerClk, fracClkOne, fracClkZero};
   wire logic [3:0] agree = ~(syncB_reg ^ syncC_reg);
   wire logic [3:0] pinRise = agree & syncB_reg & ~pinLvl_reg;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         syncA_reg <= 4'h0;
         syncB_reg <= 4'h0;
         syncC_reg <= 4'h0;
         pinLvl_reg <= 4'h0;
      end else begin
         syncA_reg <= pinRaw;
         syncB_reg <= syncA_reg;
         syncC_reg <= syncB_reg;
         pinLvl_reg <= (agree & syncB_reg) | (~agree & pinLvl_reg);
      end
   end

   // -----------------------------------------------------------------
   // dividers: 0 channel zero, 1 channel one, 2 aux reference clock
   // -----------------------------------------------------------------
   wire logic [2:0] ch1Ratio = fmtCtl_reg[ocr_pkg::CH1_RATIO_LSB +: 3];
   wire logic [1:0] auxDiv = outCtl_reg[ocr_pkg::AUX_DIV_LSB +: 2];
   wire logic [CNT_W-1:0] divHalf [3];
   wire logic [2:0] divSrc;
   assign divHalf[0] = ratioHalf(chanCtl_reg[ocr_pkg::CH0_RATIO_LSB +: 3]);
   assign divHalf[1] = ratioHalf(ch1Ratio);
   assign divHalf[2] = auxHalf(auxDiv);
   assign divSrc[0] = chanCtl_reg[ocr_pkg::CH0_SRC_POS];
   assign divSrc[1] = chanCtl_reg[ocr_pkg::CH1_SRC_POS];
   assign divSrc[2] = outCtl_reg[ocr_pkg::AUX_SRC_POS];
   logic [2:0] divClk_reg;

   generate
      for (genvar i = 0; i < 3; i++) begin : g_div
         logic [CNT_W-1:0] cnt_reg;
         wire logic tick = divSrc[i] ? pinRise[1] : pinRise[0];
         // at-or-above, not equal: a ratio cut below the running count wraps at once
         wire logic wrap = cnt_reg >= divHalf[i] - CNT_W'(1);
         // a half period of N source edges gives divide by 2N
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               cnt_reg <= '0;
               divClk_reg[i] <= 1'b0;
            end else if (divHalf[i] == '0) begin
               cnt_reg <= '0;
               divClk_reg[i] <= 1'b0;
            end else if (tick) begin
               cnt_reg <= wrap ? '0 : cnt_reg + CNT_W'(1);
               divClk_reg[i] <= wrap ? ~divClk_reg[i] : divClk_reg[i];
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // routing, enables and pin drive
   // -----------------------------------------------------------------
   wire logic comb0 = chanCtl_reg[ocr_pkg::CH0_COMB_POS];
   wire logic comb1 = chanCtl_reg[ocr_pkg::CH1_COMB_POS];
   wire logic combLvl = pinLvl_reg[2];
   wire logic firstSrc = comb0 ? combLvl : divClk_reg[0];
   // the combiner flag of channel one overrides the route bit
   wire logic routeOne = outCtl_reg[ocr_pkg::SEC_ROUTE_POS];
   wire logic secondSrc = comb1 ? combLvl : routeOne ? divClk_reg[1] : firstSrc;
   wire logic oeActive = pinLvl_reg[3] ^ outCtl_reg[ocr_pkg::OE_POL_POS];
   wire logic firstOn = outCtl_reg[ocr_pkg::FIRST_ON_POS] && oeActive;
   wire logic secondOn = outCtl_reg[ocr_pkg::SEC_ON_POS] && oeActive;
   wire logic [2:0] firstFmt = fmtCtl_reg[ocr_pkg::FIRST_FMT_LSB +: 3];
   wire logic [2:0] secondFmt = outCtl_reg[ocr_pkg::SEC_FMT_LSB +: 3];
   wire logic [1:0] auxFunc = outCtl_reg[ocr_pkg::AUX_FUNC_LSB +: 2];
   wire logic firstIdle = chanCtl_reg[ocr_pkg::FIRST_IDLE_POS];
   wire logic secondIdle = chanCtl_reg[ocr_pkg::SEC_IDLE_POS];
   wire ocr_pkg::ocr_pair_t firstNext = pairOut(firstOn, firstFmt, firstSrc,
                                                firstIdle);
   wire ocr_pkg::ocr_pair_t secondNext = pairOut(secondOn, secondFmt, secondSrc,
                                                 secondIdle);
   wire ocr_pkg::ocr_pin_t auxNext = auxFunc == ocr_pkg::AUX_TRI ? idlePin(1'b1) :
                                     auxFunc == ocr_pkg::AUX_REFCLK ? drivePin(divClk_reg[2]) :
                                     auxFunc == ocr_pkg::AUX_READY ? drivePin(clockReady) :
                                     idlePin(1'b0);
   // edge rate only reaches the driver in differential formats
   wire logic [1:0] firstRateNext = firstFmt[2] ? 2'h0 : fmtCtl_reg[ocr_pkg::FIRST_RATE_LSB +: 2];
   wire logic [1:0] secondRateNext = secondFmt[2] ? 2'h0 : outCtl_reg[ocr_pkg::SEC_RATE_LSB +: 2];

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         firstClockOutput <= '{pos: '{drv: 1'b0, oeN: 1'b1}, neg: '{drv: 1'b0, oeN: 1'b1}};
         secondClockOutput <= '{pos: '{drv: 1'b0, oeN: 1'b1}, neg: '{drv: 1'b0, oeN: 1'b1}};
         auxPin <= '{drv: 1'b0, oeN: 1'b1};
         firstDrvFormat <= 3'h0;
         secondDrvFormat <= 3'h0;
         firstEdgeRate <= 2'h0;
         secondEdgeRate <= 2'h0;
      end else begin
         firstClockOutput <= firstNext;
         secondClockOutput <= secondNext;
         auxPin <= auxNext;
         firstDrvFormat <= firstFmt;
         secondDrvFormat <= secondFmt;
         firstEdgeRate <= firstRateNext;
         secondEdgeRate <= secondRateNext;
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_fuse_load_copy: assert property (!fuseLoaded_reg |=>
      chanCtl_reg == $past(fuseChanCtl) && fmtCtl_reg == $past(fuseFmtCtl))
      else $error("fuse defaults not loaded");
   a_numerator_write: assert property (fuseLoaded_reg && wrFmt |=>
      fmtCtl_reg[ocr_pkg::SEC_NUM_HI_LSB +: 8] == $past(regWrData[ocr_pkg::SEC_NUM_HI_LSB +: 8]))
      else $error("numerator byte write lost");
   a_reserved_reads_zero: assert property (regAddr == ocr_pkg::ADDR_OUT_CTL |=>
      !regRdData[15])
      else $error("reserved bit reads one");
   a_channel_one_ratio_two: assert property (ch1Ratio == 3'h1 && $past(ch1Ratio) == 3'h1
      && (divSrc[1] ? pinRise[1] : pinRise[0]) |=> divClk_reg[1] != $past(divClk_reg[1]))
      else $error("channel one divide by two missed an edge");
   a_ch1_off_low: assert property (ch1Ratio == 3'h0 |=> !divClk_reg[1])
      else $error("disabled channel divider toggles");
   a_first_idle_state: assert property (!outCtl_reg[ocr_pkg::FIRST_ON_POS] |=>
      firstClockOutput.pos.oeN == $past(chanCtl_reg[ocr_pkg::FIRST_IDLE_POS])
      && !firstClockOutput.pos.drv)
      else $error("disabled first output not in idle state");
   a_oe_pin_gate: assert property (!oeActive |=>
      !secondClockOutput.neg.drv && secondClockOutput.neg.oeN == $past(secondIdle))
      else $error("output driven while enable pin inactive");
   a_antiphase_pins: assert property (firstOn && firstFmt == ocr_pkg::FMT_CMOS_ANTI |=>
      firstClockOutput.pos.drv != firstClockOutput.neg.drv && !firstClockOutput.neg.oeN)
      else $error("antiphase pins not complementary");
   a_aux_ready_pin: assert property (auxFunc == ocr_pkg::AUX_READY |=>
      auxPin.drv == $past(clockReady) && !auxPin.oeN)
      else $error("aux pin does not show clock ready");
   a_edge_rate_cmos: assert property (secondFmt[2] |=> secondEdgeRate == 2'h0)
      else $error("edge rate applied to single-ended format");
   a_cmos_pos_only: assert property (firstOn && firstFmt == ocr_pkg::FMT_CMOS_POS |=>
      !firstClockOutput.pos.oeN && !firstClockOutput.neg.drv
      && firstClockOutput.neg.oeN == $past(firstIdle))
      else $error("positive-only format drives the negative pin");
   a_second_off_idle: assert property (!outCtl_reg[ocr_pkg::SEC_ON_POS] |=>
      !secondClockOutput.pos.drv && secondClockOutput.pos.oeN == $past(secondIdle))
      else $error("disabled second output not in idle state");
   a_aux_ref_off: assert property (auxFunc == ocr_pkg::AUX_REFCLK
      && auxDiv == 2'h0 && $past(auxDiv) == 2'h0 |=> !auxPin.drv && !auxPin.oeN)
      else $error("disabled reference clock toggles");

   c_fuse_then_write: cover property (!fuseLoaded_reg ##1 wrOut ##1 regRdData != 16'h0000);
   c_aux_refclk_toggle: cover property (auxFunc == ocr_pkg::AUX_REFCLK && $rose(auxPin.drv));
   c_second_from_ch1: cover property (secondOn && outCtl_reg[ocr_pkg::SEC_ROUTE_POS]
      && $rose(secondClockOutput.pos.drv));
   c_first_antiphase: cover property (firstOn && firstFmt == ocr_pkg::FMT_CMOS_ANTI
      ##1 $rose(firstClockOutput.neg.drv));
endmodule : ocr_output_clock_routing

//--- dv/ocr_output_clock_routing_bench.sv
// testbench: registers, formats, enables and divider ratios of the output clock routing block
`timescale 1ns/1ps
`define CHK(gotV, expV) begin \
   checks++; \
   if ((gotV) !== (expV)) begin \
      numErrors++; \
      $display("FAIL t=%0t got %0h exp %0h", $time, (gotV), (expV)); \
   end \
end

module ocr_output_clock_routing_bench;
   typedef struct packed {
      logic [15:0] chan;
      logic [15:0] fmt;
      logic [15:0] out;
      logic pin;
      logic [2:0] f1;
      logic [2:0] f2;
      logic [1:0] r1;
      logic [1:0] r2;
      logic [3:0] oeN;
      logic auxOeN;
      logic auxDrv;
   } ocr_row_t;

   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic regWrEn = 1'b0;
   logic [15:0] regWrData = 16'h0000;
   logic [15:0] regRdData;
   logic [15:0] fuseChanCtl = 16'h0021;
   logic [15:0] fuseFmtCtl = 16'h2bcd;
   logic [15:0] fuseOutCtl = 16'h4706;
   logic fracClkZero = 1'b0;
   logic fracClkOne = 1'b0;
   logic combinerClk = 1'b0;
   logic outEnablePin = 1'b0;
   logic clockReady = 1'b1;
   ocr_pkg::ocr_pair_t firstClockOutput;
   ocr_pkg::ocr_pair_t secondClockOutput;
   ocr_pkg::ocr_pin_t auxPin;
   logic [2:0] firstDrvFormat;
   logic [2:0] secondDrvFormat;
   logic [1:0] firstEdgeRate;
   logic [1:0] secondEdgeRate;
   wire logic [3:0] oeSeen = {firstClockOutput.pos.oeN, firstClockOutput.neg.oeN,
                              secondClockOutput.pos.oeN, secondClockOutput.neg.oeN};
   int numErrors = 0;
   int checks = 0;
   int cycles = 0;
   int tFirst, tSecond, tAux, k, r, d;
   int nTab[8] = '{0, 1, 2, 3, 4, 5, 10, 20};
   // ordinary cases: configuration words, enable pin, expected driver controls
   ocr_row_t rows[6] = '{
      '{16'h0000, 16'h000b, 16'h654b, 1'b0, 3'h3, 3'h2, 2'h1, 2'h2, 4'h0, 1'b0, 1'b1},
      '{16'h0020, 16'h001c, 16'h2577, 1'b0, 3'h4, 3'h5, 2'h0, 2'h0, 4'h4, 1'b1, 1'b0},
      '{16'h0020, 16'h0016, 16'h043d, 1'b0, 3'h6, 3'h7, 2'h0, 2'h0, 4'hc, 1'b0, 1'b0},
      '{16'h0060, 16'h0001, 16'h4502, 1'b0, 3'h1, 3'h0, 2'h0, 2'h0, 4'hf, 1'b0, 1'b0},
      '{16'h0060, 16'h0001, 16'h4502, 1'b1, 3'h1, 3'h0, 2'h0, 2'h0, 4'h0, 1'b0, 1'b0},
      '{16'h0060, 16'h0001, 16'h4503, 1'b1, 3'h1, 3'h0, 2'h0, 2'h0, 4'hf, 1'b0, 1'b0}};

   ocr_output_clock_routing i_ocr_output_clock_routing (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdData(regRdData), .fuseChanCtl(fuseChanCtl),
      .fuseFmtCtl(fuseFmtCtl), .fuseOutCtl(fuseOutCtl), .fracClkZero(fracClkZero),
      .fracClkOne(fracClkOne), .combinerClk(combinerClk), .outEnablePin(outEnablePin),
      .clockReady(clockReady), .firstClockOutput(firstClockOutput),
      .secondClockOutput(secondClockOutput), .auxPin(auxPin), .firstDrvFormat(firstDrvFormat),
      .secondDrvFormat(secondDrvFormat), .firstEdgeRate(firstEdgeRate),
      .secondEdgeRate(secondEdgeRate));

   always #5 clk_sys = ~clk_sys;

   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic summarize();
      if (numErrors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      regAddr <= a;
      regWrEn <= 1'b1;
      regWrData <= v;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
   endtask : wr

   task automatic rdChk(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(regRdData, e)
   endtask : rdChk

   // bit 15 of the output word is never set here and bit 10 always is
   task automatic cfg(input logic [15:0] c, input logic [15:0] f, input logic [15:0] o);
      wr(ocr_pkg::ADDR_CHAN_CTL, c);
      wr(ocr_pkg::ADDR_FMT_CTL, f);
      wr(ocr_pkg::ADDR_OUT_CTL, o);
   endtask : cfg

   // runs one source at 16 clocks per period; toggles counted over the last 120 periods,
   // after 16 periods of warm-up so the synchroniser and divider phase have settled
   task automatic runClk(input int src);
      logic [2:0] prev;
      logic [2:0] cur;
      tFirst = 0;
      tSecond = 0;
      tAux = 0;
      prev = 3'h0;
      for (int i = 0; i < 136 * 16; i++) begin
         @(posedge clk_sys);
         fracClkZero <= (src == 0) && ((i % 16) < 8);
         fracClkOne <= (src == 1) && ((i % 16) < 8);
         combinerClk <= (src == 2) && ((i % 16) < 8);
         #1;
         cur = {firstClockOutput.pos.drv, secondClockOutput.pos.drv, auxPin.drv};
         if (i >= 256) begin
            tFirst += int'(cur[2] != prev[2]);
            tSecond += int'(cur[1] != prev[1]);
            tAux += int'(cur[0] != prev[0]);
         end
         prev = cur;
      end
   endtask : runClk

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 80000) begin
         numErrors++;
         summarize();
      end
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(regRdData, 16'h0000)
      `CHK({firstClockOutput.pos.oeN, secondClockOutput.neg.oeN, auxPin.oeN}, 3'h7)
      @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rdChk(ocr_pkg::ADDR_CHAN_CTL, 16'h0021);
      rdChk(ocr_pkg::ADDR_FMT_CTL, 16'h2bcd);
      rdChk(ocr_pkg::ADDR_OUT_CTL, 16'h4706);
      wr(4'h5, 16'hffff);
      rdChk(4'h5, 16'h0000);
      rdChk(ocr_pkg::ADDR_FMT_CTL, 16'h2bcd);
      for (k = 0; k < 6; k++) begin
         @(posedge clk_sys);
         outEnablePin <= rows[k].pin;
         cfg(rows[k].chan, rows[k].fmt, rows[k].out);
         repeat (8) @(posedge clk_sys);
         #1;
         `CHK(firstDrvFormat, rows[k].f1)
         `CHK(secondDrvFormat, rows[k].f2)
         `CHK(firstEdgeRate, rows[k].r1)
         `CHK(secondEdgeRate, rows[k].r2)
         `CHK(oeSeen, rows[k].oeN)
         `CHK({auxPin.oeN, auxPin.drv}, {rows[k].auxOeN, rows[k].auxDrv})
         rdChk(ocr_pkg::ADDR_OUT_CTL, rows[k].out);
         rdChk(ocr_pkg::ADDR_FMT_CTL, rows[k].fmt);
      end
      // hand-written cases: divider ratios, routing and sources
      @(posedge clk_sys);
      outEnablePin <= 1'b0;
      for (r = 0; r < 8; r++) begin
         cfg(16'h0000, {r[2:0], 13'h0000}, 16'h0583);
         runClk(0);
         `CHK(tSecond, (r == 0) ? 0 : 120 / nTab[r])
      end
      cfg(16'h0001, 16'he000, 16'h0503);
      runClk(0);
      `CHK(tSecond, 120)
      `CHK(tFirst, 120)
      cfg(16'h0100, 16'h2000, 16'h0583);
      runClk(0);
      `CHK(tSecond, 0)
      runClk(1);
      `CHK(tSecond, 120)
      cfg(16'h0080, 16'h0000, 16'h0583);
      runClk(2);
      `CHK(tSecond, 240)
      cfg(16'h0001, 16'h2006, 16'h059b);
      runClk(0);
      `CHK(secondClockOutput.neg.drv, ~secondClockOutput.pos.drv)
      `CHK(firstClockOutput.neg.drv, ~firstClockOutput.pos.drv)
      `CHK(tFirst, 120)
      cfg(16'h0000, 16'h2000, 16'h059f);
      runClk(0);
      `CHK(secondClockOutput.neg.drv, secondClockOutput.pos.drv)
      for (d = 0; d < 4; d++) begin
         cfg(16'h0000, 16'h0000, {3'h2, d[1:0], 11'h600});
         runClk(1);
         `CHK(tAux, (d == 0) ? 0 : 120 / (1 << (d - 1)))
      end
      cfg(16'h0000, 16'h0000, 16'h5c00);
      runClk(1);
      `CHK(tAux, 0)
      runClk(0);
      `CHK(tAux, 30)
      // clock-ready follows its input, not a constant
      cfg(16'h0000, 16'h0000, 16'h6400);
      @(posedge clk_sys);
      clockReady <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK({auxPin.oeN, auxPin.drv}, 2'h0)
      // reset in mid-run: pins released, fuse words reloaded, first-edge write dropped
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      fuseOutCtl <= 16'hc503;
      clockReady <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK({firstClockOutput, secondClockOutput, auxPin}, 10'h155)
      `CHK(regRdData, 16'h0000)
      @(posedge clk_sys);
      sys_rst <= 1'b0;
      regAddr <= ocr_pkg::ADDR_FMT_CTL;
      regWrEn <= 1'b1;
      regWrData <= 16'h1234;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
      rdChk(ocr_pkg::ADDR_FMT_CTL, 16'h2bcd);
      rdChk(ocr_pkg::ADDR_OUT_CTL, 16'h4503);
      summarize();
   end
endmodule : ocr_output_clock_routing_bench
